// ---- hw/pfs_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [R1] catch data and clock pins as index bits
// [R2] eight-row table picks loop_one and bank
// [R3] live bit2 switches loop_one, a, b
// [R4] a and b share one bank choice
// [R5] divider changes land glitch free
// [R6] each loop gets 8-bit q, 11-bit p
// [R7] loop_one set by bus or pins
// [R8] loop_two, loop_three set by bus only
// [R9] output e divides loop_one by 2/3/4
// [R10] loops feed the cross point switch
// [R11] oe low tristates, optionally shuts down
// [R12] suspend pin is bit2 or suspend
// [R13] six-bit load capacitor code
// [R14] bypass setting removes load capacitors
// [R15] programmable oscillator drive strength
// [R16] latched pins become serial lines afterwards
// [R17] e code: off, /4, /2, /3
// [R18] zero divide stops and tristates output
// [R19] each written byte acts at ack
// [R20] latched index bits never change again
module pfs_ctrl
	import pfs_pkg::*;
(
	input  wire logic          ref_clk,          // 125 MHz system clock
	input  wire logic          nrst,             // async reset, low
	input  pfs_pkg::pfs_wb_req_t wb_req,         // wishbone request
	output logic               wb_ack,           // wishbone ack
	output logic [31:0]        wb_dat_rd,        // wishbone read data
	input  wire logic          serial_data_pin,  // index bit0 strap, then data
	input  wire logic          serial_clock_pin, // index bit1 strap, then clock
	input  wire logic          freq_index_bit2,  // live select or suspend, pin
	input  wire logic          oe_pin_n,         // output disable / shutdown, pin
	input  wire logic [3:0]    src_edge,         // edges of ref, loops one..three
	output pfs_pkg::pfs_loop_cfg_t loop_one_cfg, // loop_one setting
	output pfs_pkg::pfs_loop_cfg_t loop_two_cfg, // loop_two setting
	output pfs_pkg::pfs_loop_cfg_t loop_three_cfg, // loop_three setting
	output logic [5:0]         cap_code,         // crystal load code
	output logic               caps_bypass,      // load caps removed
	output logic [1:0]         osc_drive,        // oscillator drive
	output logic               chip_shutdown,    // chip powered down
	output logic               serial_port_on,   // pins now serve the serial port
	output logic [4:0]         clk_out,          // output_a..output_e levels
	output logic [4:0]         clk_oe            // output enables, high drives
);
	import pfs_pkg::*;

	logic [2:0] sy1_q, sy2_q;
	logic [1:0] st_cnt_q, st_cnt_d;
	logic       strap_ok_q, strap_ok_d;
	logic [1:0] strap_q, strap_d;
	logic       ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d, rd_word, wr_word;
	pfs_ctrl_t  ctrl_q, ctrl_d;
	logic [5:0] cap_q, cap_d;
	logic [7:0] xp_q, xp_d;
	logic [18:0] lp2_q, lp2_d, lp3_q, lp3_d;
	logic [6:0] div_q [6], div_d [6];
	pfs_entry_t tbl_q [8], tbl_d [8];
	pfs_loop_cfg_t l1_q, l1_d, l2_q, l2_d, l3_q, l3_d;
	logic [4:0] oe_q, oe_d;
	logic [2:0] div_idx, act_idx;
	logic       bit2_s, oe_s, suspended, shut, wr_en, req;
	logic [2:0] loop_run;
	logic [3:0] src_live;
	logic [6:0] div_val [5];
	logic [4:0] tick, div_act;
	logic [6:0] e_val;

	// pins cross in through two flops; only the second is ever read
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sy1_q <= '0;
			sy2_q <= '0;
		end
		else
		begin
			sy1_q <= {oe_pin_n, freq_index_bit2, serial_clock_pin};
			sy2_q <= sy1_q;
		end
	end
	// serial_data_pin is caught through its own pair below
	logic sd1_q, sd2_q;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sd1_q <= 1'b0;
			sd2_q <= 1'b0;
		end
		else
		begin
			sd1_q <= serial_data_pin;
			sd2_q <= sd1_q;
		end
	end
	assign bit2_s = sy2_q[1];
	assign oe_s   = sy2_q[2];

	// strap capture waits until the synchronisers hold real pin levels
	always_comb
	begin
		st_cnt_d   = st_cnt_q;
		strap_ok_d = strap_ok_q;
		strap_d    = strap_q;
		if (!strap_ok_q)
		begin
			if (st_cnt_q == PFS_STARTUP_CYCLES)
			begin
				strap_d    = {sy2_q[0], sd2_q}; // [R1]
				strap_ok_d = 1'b1;
			end
			else
				st_cnt_d = st_cnt_q + 1'b1;
		end
	end
	// once caught, only a fresh reset releases the straps
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_cnt_q   <= '0;
			strap_ok_q <= 1'b0;
			strap_q    <= '0;
		end
		else
		begin
			st_cnt_q   <= st_cnt_d;
			strap_ok_q <= strap_ok_d;
			strap_q    <= strap_d; // [R20]
		end
	end
	assign serial_port_on = strap_ok_q; // [R16]

	// power state and table row
	assign suspended = ctrl_q.suspend_mode & ~bit2_s; // [R12]
	assign shut      = ~oe_s & ctrl_q.shutdown_en; // [R11]
	assign act_idx   = {bit2_s & ~ctrl_q.suspend_mode, strap_q}; // [R2] [R3]

	// read mux; unmapped words read zero
	assign div_idx = 3'((wb_req.adr - PFS_OFF_DIV) >> 2);
	always_comb
	begin
		rd_word = '0;
		if (wb_req.adr >= PFS_OFF_TABLE && wb_req.adr < PFS_OFF_TABLE + PFS_TABLE_SPAN)
			rd_word = 32'(tbl_q[wb_req.adr[4:2]]);
		else if (wb_req.adr >= PFS_OFF_DIV && wb_req.adr < PFS_OFF_DIV + PFS_DIV_SPAN)
			rd_word = 32'(div_q[div_idx]);
		else
			case (wb_req.adr)
				PFS_OFF_CTRL:   rd_word = 32'(ctrl_q);
				PFS_OFF_CAP:    rd_word = 32'(cap_q);
				PFS_OFF_STATUS: rd_word = 32'({oe_q, suspended, shut, l1_q.en, act_idx, bit2_s, strap_q});
				PFS_OFF_XPOINT: rd_word = 32'(xp_q);
				PFS_OFF_LOOP2:  rd_word = 32'(lp2_q);
				PFS_OFF_LOOP3:  rd_word = 32'(lp3_q);
				default:        rd_word = '0;
			endcase
	end

	// byte lanes merge into the current word; lanes not selected keep their value
	always_comb
	begin
		for (int b = 0; b < 4; b++)
			wr_word[b*8 +: 8] = wb_req.sel[b] ? wb_req.dat[b*8 +: 8] : rd_word[b*8 +: 8];
	end

	// classic slave: ack one cycle after the strobe, write lands with the ack
	assign req   = wb_req.cyc & wb_req.stb;
	assign wr_en = req & wb_req.we & ack_q;
	always_comb
	begin
		ack_d  = req & ~ack_q;
		rdat_d = ack_d ? rd_word : '0;
		ctrl_d = ctrl_q;
		cap_d  = cap_q;
		xp_d   = xp_q;
		lp2_d  = lp2_q;
		lp3_d  = lp3_q;
		div_d  = div_q;
		tbl_d  = tbl_q;
		if (wr_en) // [R19]
		begin
			if (wb_req.adr >= PFS_OFF_TABLE && wb_req.adr < PFS_OFF_TABLE + PFS_TABLE_SPAN)
				tbl_d[wb_req.adr[4:2]] = wr_word[19:0]; // [R7]
			else if (wb_req.adr >= PFS_OFF_DIV && wb_req.adr < PFS_OFF_DIV + PFS_DIV_SPAN)
				div_d[div_idx] = wr_word[6:0];
			else
				case (wb_req.adr)
					PFS_OFF_CTRL:   ctrl_d = wr_word[17:0];
					PFS_OFF_CAP:    cap_d  = wr_word[5:0]; // [R13]
					PFS_OFF_XPOINT: xp_d   = wr_word[7:0];
					PFS_OFF_LOOP2:  lp2_d  = wr_word[18:0]; // [R8]
					PFS_OFF_LOOP3:  lp3_d  = wr_word[18:0]; // [R8]
					default:        ;
				endcase
		end
	end

	// loop settings; a loop stops under shutdown or a suspend that names it
	always_comb
	begin
		loop_run = ctrl_q.loop_en & ~{3{shut}} & ~({3{suspended}} & ctrl_q.loop_susp);
		l1_d = {loop_run[0], tbl_q[act_idx].p, tbl_q[act_idx].q}; // [R6] [R3]
		l2_d = {loop_run[1], lp2_q}; // [R6]
		l3_d = {loop_run[2], lp3_q}; // [R6]
	end

	// the cross point picks ref or a loop for each of outputs a..d
	assign src_live = src_edge & {l3_q.en, l2_q.en, l1_q.en, ~shut}; // [R10]
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			tick[i] = src_live[xp_q[i*2 +: 2]];
		tick[4]    = src_live[1]; // [R9]
		div_val[0] = div_q[{2'b00, tbl_q[act_idx].bank}]; // [R4]
		div_val[1] = div_q[{2'b01, tbl_q[act_idx].bank}]; // [R4]
		div_val[2] = div_q[4];
		div_val[3] = div_q[5];
		unique case (ctrl_q.e_code) // [R17]
			PFS_E_OFF:  e_val = 7'd0;
			PFS_E_DIV4: e_val = 7'd4;
			PFS_E_DIV2: e_val = 7'd2;
			PFS_E_DIV3: e_val = 7'd3;
		endcase
		div_val[4] = e_val;
	end

	// oe pin low, a suspend that names the output or a stopped divider tristates the pin
	always_comb
	begin
		oe_d = {5{strap_ok_q & oe_s}} & ~({5{suspended}} & ctrl_q.out_susp) & div_act; // [R11] [R18]
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_q  <= 1'b0;
			rdat_q <= '0;
			ctrl_q <= PFS_CTRL_RST;
			cap_q  <= PFS_CAP_RST;
			xp_q   <= PFS_XPOINT_RST;
			lp2_q  <= '0;
			lp3_q  <= '0;
			div_q  <= '{default: PFS_DIV_RST};
			tbl_q  <= '{default: PFS_ENTRY_RST};
			l1_q   <= '0;
			l2_q   <= '0;
			l3_q   <= '0;
			oe_q   <= '0;
		end
		else
		begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
			ctrl_q <= ctrl_d;
			cap_q  <= cap_d;
			xp_q   <= xp_d;
			lp2_q  <= lp2_d;
			lp3_q  <= lp3_d;
			div_q  <= div_d;
			tbl_q  <= tbl_d;
			l1_q   <= l1_d;
			l2_q   <= l2_d;
			l3_q   <= l3_d;
			oe_q   <= oe_d;
		end
	end

	// one divider per output; e shares the structure with a fixed small ratio
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_div
			pfs_out_div #(.WIDTH(7)) u_div (
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.tick    (tick[g]),
				.div_val (div_val[g]),
				.clk_lvl (clk_out[g]),
				.active  (div_act[g])
			);
		end
	endgenerate

	assign wb_ack         = ack_q;
	assign wb_dat_rd      = rdat_q;
	assign loop_one_cfg   = l1_q;
	assign loop_two_cfg   = l2_q;
	assign loop_three_cfg = l3_q;
	assign cap_code       = cap_q; // [R13]
	assign caps_bypass    = ctrl_q.caps_bypass; // [R14]
	assign osc_drive      = ctrl_q.osc_drive; // [R15]
	assign chip_shutdown  = shut; // [R11]
	assign clk_oe         = oe_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_strap_done;
		!strap_ok_q ##1 strap_ok_q;
	endsequence

	a_strap_catch: assert property (s_strap_done |-> strap_q == $past({sy2_q[0], sd2_q})) // [R1]
		else $error("strap bits differ from pins at capture");
	a_strap_frozen: assert property (strap_ok_q |=> $stable(strap_q) && strap_ok_q) // [R20]
		else $error("latched index bits changed");
	a_loop1_row: assert property (##1 l1_q.q == $past(tbl_q[act_idx].q) && l1_q.p == $past(tbl_q[act_idx].p)) // [R3]
		else $error("loop_one not from active row");
	a_loop2_bus_only: assert property (!$past(wr_en) |-> $stable(lp2_q) && $stable(lp3_q)) // [R8]
		else $error("loop two or three changed without a write");
	a_oe_low_off: assert property (!oe_s |=> oe_q == '0) // [R11]
		else $error("outputs driven while oe pin low");
	a_shut_loops: assert property (shut |=> !l1_q.en && !l2_q.en && !l3_q.en) // [R11]
		else $error("loop running during shutdown");
	a_bank_shared: assert property ( // [R4]
		div_val[0] == (tbl_q[act_idx].bank ? div_q[1] : div_q[0])
		&& div_val[1] == (tbl_q[act_idx].bank ? div_q[3] : div_q[2]))
		else $error("outputs a and b use different banks");
	a_e_ratio: assert property (ctrl_q.e_code == PFS_E_DIV3 |-> div_val[4] == 7'd3) // [R17]
		else $error("output e ratio code mapped wrong");
	a_ack_once: assert property (req && !ack_q |=> ack_q ##1 !ack_q) // [R19]
		else $error("ack not a single cycle");

endmodule : pfs_ctrl

// ---- hw/pfs_pkg.sv ----
package pfs_pkg;

	// bus request as the master presents it
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pfs_wb_req_t;

	// control word: loop enables, power options, oscillator and output E setup
	typedef struct packed {
		logic [2:0] loop_susp;    // loops stopped while suspended
		logic [4:0] out_susp;     // outputs a..e tristated while suspended
		logic [1:0] e_code;       // output_e_ratio_code
		logic [1:0] osc_drive;    // oscillator inverter strength
		logic       caps_bypass;  // remove load caps for a driven reference
		logic       suspend_mode; // bit2 pin acts as suspend input
		logic       shutdown_en;  // oe pin low also shuts the chip down
		logic [2:0] loop_en;      // loop_one..loop_three enables
	} pfs_ctrl_t;

	// one row of the frequency table
	typedef struct packed {
		logic        bank;        // divider_bank_choice for outputs a and b
		logic [10:0] p;
		logic [7:0]  q;
	} pfs_entry_t;

	// setting presented to each analog loop
	typedef struct packed {
		logic        en;
		logic [10:0] p;
		logic [7:0]  q;
	} pfs_loop_cfg_t;

	localparam logic [7:0] PFS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] PFS_OFF_CAP    = 8'h04;
	localparam logic [7:0] PFS_OFF_STATUS = 8'h08;
	localparam logic [7:0] PFS_OFF_XPOINT = 8'h0c;
	localparam logic [7:0] PFS_OFF_LOOP2  = 8'h10;
	localparam logic [7:0] PFS_OFF_LOOP3  = 8'h14;
	localparam logic [7:0] PFS_OFF_DIV    = 8'h18; // a0,a1,b0,b1,c,d
	localparam logic [7:0] PFS_OFF_TABLE  = 8'h40; // eight rows
	localparam logic [7:0] PFS_DIV_SPAN   = 8'h18;
	localparam logic [7:0] PFS_TABLE_SPAN = 8'h20;

	localparam pfs_ctrl_t  PFS_CTRL_RST   = '0;
	localparam logic [5:0] PFS_CAP_RST    = 6'h00;
	localparam logic [7:0] PFS_XPOINT_RST = 8'h00;
	localparam logic [6:0] PFS_DIV_RST    = 7'h00;
	localparam pfs_entry_t PFS_ENTRY_RST  = '0;

	// output_e_ratio_code to divide value
	localparam logic [1:0] PFS_E_OFF  = 2'b00;
	localparam logic [1:0] PFS_E_DIV4 = 2'b01;
	localparam logic [1:0] PFS_E_DIV2 = 2'b10;
	localparam logic [1:0] PFS_E_DIV3 = 2'b11;

	// cycles after reset release before the index pins are caught
	localparam logic [1:0] PFS_STARTUP_CYCLES = 2'h3;

endpackage : pfs_pkg

// ---- hw/pfs_out_div.sv ----
`timescale 1ns/1ps
module pfs_out_div
	import pfs_pkg::*;
#(
	parameter int WIDTH = 7
)(
	input  wire logic             ref_clk,  // system clock
	input  wire logic             nrst,     // async reset, low
	input  wire logic             tick,     // one pulse per source edge
	input  wire logic [WIDTH-1:0] div_val,  // requested divide, 0 is off
	output logic                  clk_lvl,  // divided output level
	output logic                  active    // divider running
);
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic [WIDTH-1:0] cur_q, cur_d;
	logic             out_q, out_d;

	// toggling every div edges gives a 50% duty even for odd values
	always_comb
	begin
		cnt_d = cnt_q;
		cur_d = cur_q;
		out_d = out_q;
		if (cur_q == '0)
		begin
			cnt_d = '0;
			out_d = 1'b0;
			cur_d = div_val; // [R18]
		end
		else if (tick)
		begin
			if (cnt_q == cur_q - 1'b1)
			begin
				cnt_d = '0;
				// a stop request ends on a low level, never on a runt high pulse
				out_d = ~out_q & (div_val != '0);
				cur_d = div_val; // [R5]
			end
			else
				cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			cur_q <= '0;
			out_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			cur_q <= cur_d;
			out_q <= out_d;
		end
	end

	assign clk_lvl = out_q;
	assign active  = (cur_q != '0);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_level_only_at_count: assert property ($changed(out_q) |-> $past(tick) && $past(cnt_q) == $past(cur_q) - 1'b1) // [R5]
		else $error("output toggled away from a phase boundary");
	a_value_only_at_edge: assert property ($changed(cur_q) && $past(cur_q) != '0 |-> $past(tick) && $past(cnt_q) == $past(cur_q) - 1'b1) // [R5]
		else $error("divide value changed mid phase");
	a_zero_holds_low: assert property (cur_q == '0 |=> !out_q) // [R18]
		else $error("stopped divider output not low");

endmodule : pfs_out_div

// ---- testbench/pfs_board.sv ----
`timescale 1ns/1ps
module pfs_board
(
	input  wire logic       ref_clk,          // system clock
	input  wire logic [1:0] strap,            // index levels held before start-up
	input  wire logic       b2_req,           // wanted bit2 level
	input  wire logic       oe_n_req,         // wanted oe level
	input  wire logic       serial_on,        // device has caught the straps
	output logic            serial_data_pin,  // data pin, bit0 strap
	output logic            serial_clock_pin, // clock pin, bit1 strap
	output logic            freq_index_bit2,  // live select pin
	output logic            oe_pin_n,         // output disable pin
	output logic [3:0]      src_edge          // one pulse per source edge
);
	logic [1:0] traffic_q = 2'h0;

	// busy traffic after capture, so a strap that follows the pins shows up
	always @(posedge ref_clk)
		traffic_q <= traffic_q + 2'h1;

	// straps stand from time zero; afterwards the pins carry serial traffic
	assign serial_data_pin  = serial_on ? traffic_q[1] : strap[0];
	assign serial_clock_pin = serial_on ? traffic_q[0] : strap[1];
	assign freq_index_bit2  = b2_req;
	assign oe_pin_n         = oe_n_req;
	assign src_edge         = 4'hf; // every source ticks each cycle
endmodule : pfs_board

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb;
	import pfs_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	pfs_wb_req_t wb_req = '0;
	logic b2_req = 1'b1;
	logic oe_req = 1'b1;
	logic wb_ack, sdp, scp, b2, oe_n, caps_bypass, chip_shutdown, serial_port_on;
	logic [31:0] wb_dat_rd, rd;
	logic [3:0] src_edge;
	logic [5:0] cap_code;
	logic [1:0] osc_drive;
	logic [4:0] clk_out, clk_oe;
	pfs_loop_cfg_t cfg1, cfg2, cfg3;
	pfs_ctrl_t cv = '0;
	int fail_count = 0;
	int checked = 0;
	int n;

	always #4 ref_clk = ~ref_clk;

	pfs_board board (.ref_clk(ref_clk), .strap(2'b01), .b2_req(b2_req), .oe_n_req(oe_req),
		.serial_on(serial_port_on), .serial_data_pin(sdp), .serial_clock_pin(scp),
		.freq_index_bit2(b2), .oe_pin_n(oe_n), .src_edge(src_edge));

	pfs_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_rd(wb_dat_rd),
		.serial_data_pin(sdp), .serial_clock_pin(scp), .freq_index_bit2(b2), .oe_pin_n(oe_n),
		.src_edge(src_edge), .loop_one_cfg(cfg1), .loop_two_cfg(cfg2), .loop_three_cfg(cfg3),
		.cap_code(cap_code), .caps_bypass(caps_bypass), .osc_drive(osc_drive),
		.chip_shutdown(chip_shutdown), .serial_port_on(serial_port_on), .clk_out(clk_out), .clk_oe(clk_oe));

	// one classic cycle; held until ack is sampled, data taken at that edge
	// the watchdog alone ends a wait that never sees ack
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		do
		begin
			@(posedge ref_clk);
		end
		while (wb_ack !== 1'b1);
		rd = wb_dat_rd;
		wb_req <= '0;
	endtask : wb

	// cycles between two rising edges of one output, bounded
	task period(input int i, output int p);
		int k;
		logic last;
		k = 0;
		p = -1;
		last = 1'b1;
		while (k < 200)
		begin
			@(posedge ref_clk);
			k++;
			if (clk_out[i] === 1'b1 && last === 1'b0)
			begin
				if (p >= 0)
					break;
				p = 0;
			end
			if (p >= 0)
				p++;
			last = clk_out[i];
		end
	endtask : period

	task conclude;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		`CHK("serial_port_on", 1'b1, serial_port_on)
		wb(0, PFS_OFF_STATUS, 32'h0000_0000);
		`CHK("straps", 2'b01, rd[1:0])
		wb(0, PFS_OFF_CTRL, 32'h0000_0000);
		`CHK("ctrl reset", 32'h0000_0000, rd)
		wb(1, 8'h30, 32'hffff_ffff);
		wb(0, 8'h30, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd)
		$display("test reset done");
		// rows 1 and 5 are the two reachable with straps 01
		wb(1, 8'h44, {12'h000, 1'b0, 11'h123, 8'h45});
		wb(1, 8'h54, {12'h000, 1'b1, 11'h7ff, 8'h01});
		wb(1, 8'h18, 32'h0000_0003);
		wb(1, 8'h1c, 32'h0000_0005);
		wb(1, 8'h20, 32'h0000_0002);
		wb(1, 8'h24, 32'h0000_0007);
		wb(1, PFS_OFF_LOOP2, {13'h0000, 11'h2aa, 8'h55});
		cv.loop_en = 3'b111;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (30) @(posedge ref_clk);
		`CHK("loop one", {1'b1, 11'h7ff, 8'h01}, cfg1)
		period(0, n);
		`CHK("a bank1", 10, n)
		period(1, n);
		`CHK("b bank1", 14, n)
		`CHK("loop two", {1'b1, 11'h2aa, 8'h55}, cfg2)
		b2_req <= 1'b0;
		repeat (30) @(posedge ref_clk);
		`CHK("loop one", {1'b1, 11'h123, 8'h45}, cfg1)
		period(0, n);
		`CHK("a bank0", 6, n)
		period(1, n);
		`CHK("b bank0", 4, n)
		`CHK("loop two", {1'b1, 11'h2aa, 8'h55}, cfg2)
		// a from loop three, b loop two, c loop one, d the reference
		wb(1, PFS_OFF_XPOINT, 32'h0000_001b);
		wb(0, PFS_OFF_XPOINT, 32'h0000_0000);
		`CHK("xpoint", 32'h0000_001b, rd)
		wb(1, 8'h28, 32'h0000_0003);
		wb(1, 8'h2c, 32'h0000_0004);
		repeat (30) @(posedge ref_clk);
		period(2, n);
		`CHK("c from loop one", 6, n)
		period(3, n);
		`CHK("d from ref", 8, n)
		// a stopped loop three must starve output a of edges
		cv.loop_en = 3'b011;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (10) @(posedge ref_clk);
		period(0, n);
		`CHK("a from loop three", -1, n)
		cv.loop_en = 3'b111;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (10) @(posedge ref_clk);
		$display("test table done");
		for (int c = 1; c < 4; c++)
		begin
			cv.e_code = c[1:0];
			wb(1, PFS_OFF_CTRL, {14'h0000, cv});
			repeat (30) @(posedge ref_clk);
			period(4, n);
			`CHK("e period", (c == 1) ? 8 : 2 * c, n)
		end
		cv.e_code = PFS_E_OFF;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (30) @(posedge ref_clk);
		`CHK("e off", 1'b0, clk_oe[4])
		wb(1, 8'h18, 32'h0000_0000);
		repeat (30) @(posedge ref_clk);
		`CHK("a zero", 1'b0, clk_oe[0])
		$display("test dividers done");
		// suspend masks output b and loop three only
		b2_req <= 1'b1;
		cv.suspend_mode = 1'b1;
		cv.out_susp = 5'b00010;
		cv.loop_susp = 3'b100;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (10) @(posedge ref_clk);
		`CHK("suspend row", {1'b1, 11'h123, 8'h45}, cfg1)
		`CHK("b before suspend", 1'b1, clk_oe[1])
		b2_req <= 1'b0;
		repeat (10) @(posedge ref_clk);
		`CHK("b suspended", 1'b0, clk_oe[1])
		`CHK("loop three suspended", 1'b0, cfg3.en)
		`CHK("loop two running", 1'b1, cfg2.en)
		b2_req <= 1'b1;
		cv.suspend_mode = 1'b0;
		cv.out_susp = 5'b00000;
		cv.loop_susp = 3'b000;
		wb(1, PFS_OFF_CAP, 32'h0000_003f);
		wb(0, PFS_OFF_CAP, 32'h0000_0000);
		`CHK("cap read", 32'h0000_003f, rd)
		`CHK("cap code", 6'h3f, cap_code)
		cv.caps_bypass = 1'b1;
		cv.osc_drive = 2'b10;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (2) @(posedge ref_clk);
		`CHK("bypass", 1'b1, caps_bypass)
		`CHK("drive", 2'b10, osc_drive)
		$display("test oscillator done");
		oe_req <= 1'b0;
		repeat (10) @(posedge ref_clk);
		`CHK("oe off", 5'h00, clk_oe)
		`CHK("no shutdown", 1'b0, chip_shutdown)
		cv.shutdown_en = 1'b1;
		wb(1, PFS_OFF_CTRL, {14'h0000, cv});
		repeat (2) @(posedge ref_clk);
		`CHK("shutdown", 1'b1, chip_shutdown)
		oe_req <= 1'b1;
		wb(0, PFS_OFF_STATUS, 32'h0000_0000);
		`CHK("straps kept", 2'b01, rd[1:0])
		$display("test power done");
		conclude;
	end

	// far above the several hundred cycles the tests take
	initial
	begin
		#(8 * 20000);
		fail_count++;
		conclude;
	end
endmodule : tb
